// >>> rtl/fhh_pkg.sv
// Constants and types shared by both ends of the coprocessor handshake
// Summary of operation
// - Internal logic steps at half the doubled clock
// - Host holds clear 40, waits 50 before opcode
// - Execution-active rises exactly 4 after write, lasts at least 6
// - Fault active 6 periods before execution-active drops
// - Fault waits 6 periods after operand request drops
// - Opcode write to next write spaced 6 periods
// - Operand write to next operand spaced 8 periods
// - Execution-active spans execution; operand requests inside it
// - Opcodes must begin with escape pattern 11011
package fhh_pkg;
    // Periods below except EXEC_TICKS count clk_i cycles, the doubled clock
    localparam int CLK_HZ = 20_000_000;
    localparam logic [7:0] CLEAR_HOLD = 8'h28;
    localparam logic [7:0] CLEAR_RECOVER = 8'h32;
    localparam logic [7:0] BUSY_DELAY = 8'h04;
    localparam logic [3:0] BUSY_MIN = 4'h6;
    localparam logic [3:0] FAULT_LEAD = 4'h6;
    localparam logic [3:0] REQ_TO_FAULT = 4'h6;
    localparam logic [3:0] OPC_GAP = 4'h6;
    localparam logic [3:0] OPND_GAP = 4'h8;
    localparam logic [3:0] AGE_MAX = 4'hF;
    // Execution length in internal (half-rate) cycles
    localparam logic [7:0] EXEC_TICKS = 8'h08;
    // Opcode field layout
    localparam logic [4:0] ESC_CODE = 5'h1B;
    localparam int ESC_MSB = 15;
    localparam int ESC_LSB = 11;
    localparam int MOD_MSB = 7;
    localparam int MOD_LSB = 6;
    localparam logic [1:0] MOD_REG = 2'h3;

    typedef enum logic [2:0] {
        FHH_D_IDLE = 3'h0,
        FHH_D_DLY = 3'h1,
        FHH_D_OPREQ = 3'h3,
        FHH_D_EXEC = 3'h2,
        FHH_D_FAULT = 3'h6
    } fhh_dev_state_t;

    typedef enum logic [1:0] {
        FHH_H_HOLD = 2'h0,
        FHH_H_RECOVER = 2'h1,
        FHH_H_READY = 2'h3
    } fhh_host_state_t;
endpackage

// >>> rtl/fhh_link_if.sv
// Link between the host and the coprocessor
`timescale 1ns/1ps
interface fhh_link_if (
    input wire logic clk_i
);
    logic chip_clear_in;
    logic xfer_done;
    logic xfer_opcode;
    logic [31:0] xfer_data;
    logic exec_active;
    logic operand_xfer_request;
    logic numeric_fault;

    modport dev (
        input chip_clear_in, xfer_done, xfer_opcode, xfer_data,
        output exec_active, operand_xfer_request, numeric_fault
    );
    modport host (
        output chip_clear_in, xfer_done, xfer_opcode, xfer_data,
        input exec_active, operand_xfer_request, numeric_fault
    );
endinterface

// >>> rtl/fhh_copro.sv
// Coprocessor end of the handshake: timing of execution-active and fault
`timescale 1ns/1ps
module fhh_copro
    import fhh_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    fhh_link_if.dev link,
    input wire logic fault_i,
    output logic [15:0] opcode_o,
    output logic opcode_valid_o,
    output logic [31:0] operand_o,
    output logic operand_valid_o
);
    typedef struct packed {
        fhh_dev_state_t st;
        logic phase;
        logic [7:0] cnt;
        logic [3:0] busy_age;
        logic [3:0] gap;
        logic [3:0] flt_age;
        logic busy;
        logic req;
        logic fault;
        logic [15:0] opc;
        logic opc_v;
        logic [31:0] opnd;
        logic opnd_v;
    } fhh_dev_t;

    localparam fhh_dev_t DEV_RST = '{
        st: FHH_D_IDLE, phase: 1'b0, cnt: 8'h00, busy_age: 4'h0,
        gap: 4'h0, flt_age: 4'h0, busy: 1'b0, req: 1'b0, fault: 1'b0,
        opc: 16'h0000, opc_v: 1'b0, opnd: 32'h0000_0000, opnd_v: 1'b0
    };

    fhh_dev_t s_r;
    fhh_dev_t s_nxt;
    logic esc_ok;
    logic opc_wr;
    logic opnd_wr;

    // Escape class check on the leading five bits
    assign esc_ok = link.xfer_data[ESC_MSB:ESC_LSB] == ESC_CODE;
    assign opc_wr = link.xfer_done && link.xfer_opcode;
    assign opnd_wr = link.xfer_done && !link.xfer_opcode;

    // Next-state logic
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.phase = ~s_r.phase;
        s_nxt.opc_v = 1'b0;
        s_nxt.opnd_v = 1'b0;
        // Saturating ages: value 1 in the first cycle of the condition
        if (s_r.busy && s_r.busy_age != AGE_MAX)
            s_nxt.busy_age = s_r.busy_age + 4'h1;
        if (s_r.gap != 4'h0 && s_r.gap != AGE_MAX)
            s_nxt.gap = s_r.gap + 4'h1;
        if (s_r.fault && s_r.flt_age != AGE_MAX)
            s_nxt.flt_age = s_r.flt_age + 4'h1;
        unique case (s_r.st)
            FHH_D_IDLE:
            begin
                // Non-escape opcodes are dropped silently
                if (opc_wr && esc_ok)
                begin
                    s_nxt.opc = link.xfer_data[15:0];
                    s_nxt.opc_v = 1'b1;
                    s_nxt.fault = 1'b0;
                    s_nxt.flt_age = 4'h0;
                    s_nxt.gap = 4'h0;
                    s_nxt.cnt = BUSY_DELAY - 8'h02;
                    s_nxt.st = FHH_D_DLY;
                end
            end
            FHH_D_DLY:
            begin
                if (s_r.cnt == 8'h00)
                begin
                    s_nxt.busy = 1'b1;
                    s_nxt.busy_age = 4'h1;
                    // Memory forms need one operand word from the host
                    if (s_r.opc[MOD_MSB:MOD_LSB] != MOD_REG)
                    begin
                        s_nxt.req = 1'b1;
                        s_nxt.st = FHH_D_OPREQ;
                    end
                    else
                    begin
                        s_nxt.cnt = EXEC_TICKS;
                        s_nxt.st = FHH_D_EXEC;
                    end
                end
                else
                    s_nxt.cnt = s_r.cnt - 8'h01;
            end
            FHH_D_OPREQ:
            begin
                if (opnd_wr)
                begin
                    s_nxt.opnd = link.xfer_data;
                    s_nxt.opnd_v = 1'b1;
                    s_nxt.req = 1'b0;
                    s_nxt.gap = 4'h1;
                    s_nxt.cnt = EXEC_TICKS;
                    s_nxt.st = FHH_D_EXEC;
                end
            end
            FHH_D_EXEC:
            begin
                // Execution counts half-rate ticks only
                if (s_r.cnt != 8'h00)
                begin
                    if (s_r.phase)
                        s_nxt.cnt = s_r.cnt - 8'h01;
                end
                else if (fault_i)
                begin
                    // Hold the fault back until the request is long gone
                    if (s_r.gap == 4'h0 || s_r.gap >= REQ_TO_FAULT)
                    begin
                        s_nxt.fault = 1'b1;
                        s_nxt.flt_age = 4'h1;
                        s_nxt.st = FHH_D_FAULT;
                    end
                end
                else if (s_r.busy_age >= BUSY_MIN)
                begin
                    s_nxt.busy = 1'b0;
                    s_nxt.st = FHH_D_IDLE;
                end
            end
            FHH_D_FAULT:
            begin
                // Fault stays up until the next accepted opcode or a clear from the host
                if (s_r.flt_age >= FAULT_LEAD && s_r.busy_age >= BUSY_MIN)
                begin
                    s_nxt.busy = 1'b0;
                    s_nxt.st = FHH_D_IDLE;
                end
            end
            default:
                s_nxt = DEV_RST;
        endcase
        // Synchronous clear from the host wins over everything
        if (link.chip_clear_in)
            s_nxt = DEV_RST;
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s_r <= DEV_RST;
        else
            s_r <= s_nxt;
    end

    // Outputs straight from state flops
    assign link.exec_active = s_r.busy;
    assign link.operand_xfer_request = s_r.req;
    assign link.numeric_fault = s_r.fault;
    assign opcode_o = s_r.opc;
    assign opcode_valid_o = s_r.opc_v;
    assign operand_o = s_r.opnd;
    assign operand_valid_o = s_r.opnd_v;
endmodule

// >>> rtl/fhh_host.sv
// Host end of the handshake: clear sequence and write spacing
`timescale 1ns/1ps
module fhh_host
    import fhh_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    fhh_link_if.host link,
    input wire logic restart_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_opcode_i,
    input wire logic [31:0] cmd_operand_i,
    output logic cmd_ready_o,
    output logic exec_active_o,
    output logic fault_o
);
    typedef struct packed {
        fhh_host_state_t st;
        logic [7:0] cnt;
        logic [3:0] gap;
        logic last_opnd;
        logic clear;
        logic xfer;
        logic xfer_opc;
        logic [31:0] data;
        logic [31:0] opnd;
        logic ready;
        logic busy;
        logic fault;
    } fhh_host_s_t;

    localparam fhh_host_s_t HOST_RST = '{
        st: FHH_H_HOLD, cnt: 8'h00, gap: 4'h0, last_opnd: 1'b0,
        clear: 1'b1, xfer: 1'b0, xfer_opc: 1'b0, data: 32'h0000_0000,
        opnd: 32'h0000_0000, ready: 1'b0, busy: 1'b0, fault: 1'b0
    };

    fhh_host_s_t s_r;
    fhh_host_s_t s_nxt;
    logic [3:0] need;

    // Spacing owed to the previous write
    assign need = s_r.last_opnd ? OPND_GAP : OPC_GAP;

    // Next-state logic
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.xfer = 1'b0;
        s_nxt.ready = 1'b0;
        s_nxt.busy = link.exec_active;
        s_nxt.fault = link.numeric_fault;
        if (s_r.gap != 4'h0 && s_r.gap != AGE_MAX)
            s_nxt.gap = s_r.gap + 4'h1;
        unique case (s_r.st)
            FHH_H_HOLD:
            begin
                if (s_r.cnt == CLEAR_HOLD - 8'h01)
                begin
                    s_nxt.clear = 1'b0;
                    s_nxt.cnt = 8'h00;
                    s_nxt.st = FHH_H_RECOVER;
                end
                else
                    s_nxt.cnt = s_r.cnt + 8'h01;
            end
            FHH_H_RECOVER:
            begin
                if (s_r.cnt == CLEAR_RECOVER - 8'h01)
                begin
                    s_nxt.gap = 4'h0;
                    s_nxt.st = FHH_H_READY;
                end
                else
                    s_nxt.cnt = s_r.cnt + 8'h01;
            end
            FHH_H_READY:
            begin
                if (restart_i)
                begin
                    s_nxt.clear = 1'b1;
                    s_nxt.cnt = 8'h00;
                    s_nxt.st = FHH_H_HOLD;
                end
                else if (s_r.ready && cmd_valid_i)
                begin
                    // Operand is kept in case the device asks for it
                    s_nxt.xfer = 1'b1;
                    s_nxt.xfer_opc = 1'b1;
                    s_nxt.data = {16'h0000, cmd_opcode_i};
                    s_nxt.opnd = cmd_operand_i;
                    s_nxt.gap = 4'h1;
                    s_nxt.last_opnd = 1'b0;
                end
                // Gap reads k at the k-th edge after the write launched
                else if (link.operand_xfer_request && !s_r.xfer &&
                    (s_r.gap == 4'h0 || s_r.gap >= need))
                begin
                    s_nxt.xfer = 1'b1;
                    s_nxt.xfer_opc = 1'b0;
                    s_nxt.data = s_r.opnd;
                    s_nxt.gap = 4'h1;
                    s_nxt.last_opnd = 1'b1;
                end
                else
                begin
                    // Ready is a flop, so it looks one cycle ahead
                    s_nxt.ready = !link.exec_active &&
                        !link.operand_xfer_request && !s_r.xfer &&
                        !s_r.ready &&
                        (s_r.gap == 4'h0 || s_r.gap >= need - 4'h1);
                end
            end
            default:
                s_nxt = HOST_RST;
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s_r <= HOST_RST;
        else
            s_r <= s_nxt;
    end

    assign link.chip_clear_in = s_r.clear;
    assign link.xfer_done = s_r.xfer;
    assign link.xfer_opcode = s_r.xfer_opc;
    assign link.xfer_data = s_r.data;
    assign cmd_ready_o = s_r.ready;
    assign exec_active_o = s_r.busy;
    assign fault_o = s_r.fault;
endmodule

// >>> sim/fhh_link_chk.sv
// Timing checks on the link between host and coprocessor
`timescale 1ns/1ps
module fhh_link_chk
    import fhh_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_clear_in,
    input wire logic xfer_done,
    input wire logic xfer_opcode,
    input wire logic [31:0] xfer_data,
    input wire logic exec_active,
    input wire logic operand_xfer_request,
    input wire logic numeric_fault
);
    logic [7:0] clr_r;
    logic [7:0] rec_r;
    logic [3:0] qt_r;
    logic opc;
    assign opc = xfer_done && xfer_opcode;

    // Run lengths; rec_r and qt_r saturate so long idle spells never wrap, clr_r wraps
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            clr_r <= 8'h00;
            rec_r <= 8'h00;
            qt_r <= 4'hF;
        end
        else
        begin
            clr_r <= chip_clear_in ? clr_r + 8'h01 : 8'h00;
            rec_r <= chip_clear_in ? 8'h00 : rec_r + {7'h00, rec_r != 8'hFF};
            qt_r <= operand_xfer_request ? 4'h0 : qt_r + {3'h0, qt_r != 4'hF};
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    busy_delay_a: assert property (opc && xfer_data[15:11] == 5'h1B
        && !exec_active |=> !exec_active [*3] ##1 exec_active)
        else $error("execution-active not raised four cycles after write");
    busy_min_a: assert property ($rose(exec_active)
        |-> exec_active [*6])
        else $error("execution-active too short");
    fault_lead_a: assert property ($fell(exec_active) && numeric_fault
        |-> $past(numeric_fault, 6))
        else $error("fault raised too late before execution end");
    fault_gap_a: assert property ($rose(numeric_fault)
        |-> qt_r >= 4'h6)
        else $error("fault too soon after operand request fell");
    req_inside_a: assert property (operand_xfer_request
        |-> exec_active)
        else $error("operand request outside execution");
    escape_only_a: assert property (opc && xfer_data[15:11] != 5'h1B
        && !exec_active |=> !exec_active [*5])
        else $error("non-escape opcode started execution");
    clear_hold_a: assert property ($fell(chip_clear_in)
        |-> clr_r >= 8'h28)
        else $error("clear held too briefly");
    recover_gap_a: assert property (xfer_done |-> rec_r >= 8'h32)
        else $error("write too soon after clear");
    opc_gap_a: assert property (opc |=> !xfer_done [*5])
        else $error("write too soon after opcode write");
    opnd_gap_a: assert property (xfer_done && !xfer_opcode
        |=> !xfer_done [*7])
        else $error("operand writes too close");
endmodule

// >>> sim/fpu_host_handshake_timing_tb_top.sv
// Self-checking bench for both ends of the coprocessor handshake
`timescale 1ns/1ps
module fpu_host_handshake_timing_tb_top
    import fhh_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic restart_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [15:0] cmd_opcode_i = 16'h0000;
    logic [31:0] cmd_operand_i = 32'h0000_0000;
    logic fault_i = 1'b0;
    logic cmd_ready_o;
    logic fault_o;
    logic exec_active_o;
    logic opcode_valid_o;
    logic operand_valid_o;
    logic [15:0] opcode_o;
    logic [31:0] operand_o;
    int n_fail = 0;
    int check_count = 0;
    int n_opc = 0;
    int n_opnd = 0;

    // Count the one-cycle strobes of the device
    always @(posedge clk_i)
    begin
        if (opcode_valid_o === 1'b1)
            n_opc++;
        if (operand_valid_o === 1'b1)
            n_opnd++;
    end

    // 20 MHz clock
    always #25 clk_i = ~clk_i;

    fhh_link_if lk (.clk_i(clk_i));
    fhh_copro fhh_copro_inst (.clk_i(clk_i), .rst_i(rst_i), .link(lk.dev),
        .fault_i(fault_i), .opcode_o(opcode_o),
        .opcode_valid_o(opcode_valid_o),
        .operand_o(operand_o), .operand_valid_o(operand_valid_o));
    fhh_host fhh_host_inst (.clk_i(clk_i), .rst_i(rst_i), .link(lk.host),
        .restart_i(restart_i), .cmd_valid_i(cmd_valid_i),
        .cmd_opcode_i(cmd_opcode_i), .cmd_operand_i(cmd_operand_i),
        .cmd_ready_o(cmd_ready_o), .exec_active_o(exec_active_o),
        .fault_o(fault_o));
    fhh_link_chk fhh_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
        .chip_clear_in(lk.chip_clear_in), .xfer_done(lk.xfer_done),
        .xfer_opcode(lk.xfer_opcode), .xfer_data(lk.xfer_data),
        .exec_active(lk.exec_active),
        .operand_xfer_request(lk.operand_xfer_request),
        .numeric_fault(lk.numeric_fault));

    task automatic wrap_up;
        $display("Checks %0d, failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex,
        input logic [31:0] got);
        check_count++;
        if (got !== ex)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // A wait that ran out is a failure and ends the run
    task automatic lim(input int i, input int m);
        if (i >= m)
        begin
            n_fail++;
            wrap_up();
        end
    endtask

    // Clear must appear and stand its full length
    task automatic clear_seq;
        int n;
        n = 0;
        do begin @(negedge clk_i); n++; end
        while (lk.chip_clear_in !== 1'b1 && n < 20);
        lim(n, 20);
        n = 0;
        do begin @(negedge clk_i); n++; end
        while (lk.chip_clear_in === 1'b1 && n < 100);
        lim(n, 100);
        chk("clear_len", 1, n >= 40);
        $display("Test clear done");
    endtask

    // One instruction through the host command port
    task automatic run_op(input logic [15:0] op, input logic [31:0] dat,
        input logic flt);
        int i;
        int t;
        @(posedge clk_i);
        fault_i <= flt;
        cmd_valid_i <= 1'b1;
        cmd_opcode_i <= op;
        cmd_operand_i <= dat;
        i = 0;
        do begin @(negedge clk_i); i++; end
        while (cmd_ready_o !== 1'b1 && i < 300);
        lim(i, 300);
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        i = 0;
        do begin @(negedge clk_i); i++; end
        while (lk.xfer_done !== 1'b1 && i < 10);
        lim(i, 10);
        chk("xfer_kind", 1, lk.xfer_opcode);
        chk("xfer_data", {16'h0000, op}, lk.xfer_data);
        t = 0;
        do begin @(negedge clk_i); t++; end
        while (lk.exec_active !== 1'b1 && t < 12);
        if (op[ESC_MSB:ESC_LSB] != ESC_CODE)
        begin
            chk("exec_ignored", 0, lk.exec_active);
            $display("Test op %h done", op);
            return;
        end
        chk("exec_delay", 4, t);
        chk("req", op[MOD_MSB:MOD_LSB] != MOD_REG,
            lk.operand_xfer_request);
        if (op[MOD_MSB:MOD_LSB] != MOD_REG)
        begin
            i = 0;
            do begin @(negedge clk_i); i++; end
            while (!(lk.xfer_done === 1'b1 && lk.xfer_opcode === 1'b0)
                && i < 40);
            lim(i, 40);
            chk("operand_wire", dat, lk.xfer_data);
        end
        i = 0;
        do begin @(negedge clk_i); i++; end
        while (lk.exec_active === 1'b1 && i < 300);
        lim(i, 300);
        repeat (2) @(negedge clk_i);
        chk("fault", flt, fault_o);
        chk("exec_out", 0, exec_active_o);
        chk("opcode", op, opcode_o);
        if (op[MOD_MSB:MOD_LSB] != MOD_REG)
            chk("operand", dat, operand_o);
        $display("Test op %h done", op);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk_i);
        chk("clear_in_reset", 1, lk.chip_clear_in);
        chk("busy_in_reset", 0, lk.exec_active);
        rst_i <= 1'b0;
        clear_seq();
        run_op(16'hD9C1, 32'h0000_0000, 1'b0);
        run_op(16'hD905, 32'hA5A5_1234, 1'b0);
        run_op(16'hDD06, 32'h0F0F_8001, 1'b1);
        run_op(16'hDEC9, 32'h0000_0000, 1'b0);
        run_op(16'h1234, 32'h0000_0000, 1'b0);
        @(posedge clk_i);
        restart_i <= 1'b1;
        @(posedge clk_i);
        restart_i <= 1'b0;
        clear_seq();
        run_op(16'hD8C2, 32'h0000_0000, 1'b0);
        chk("opc_strobes", 5, n_opc);
        chk("opnd_strobes", 2, n_opnd);
        wrap_up();
    end
endmodule
